/* hdl/mux_ctrl_pkg.sv */
// constants and carriers for the four-channel amplifier latch controller
// assumes a 250 MHz clock and a clockless latch device on plain pins
package mux_ctrl_pkg;
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned T_PULSE_NS = 100;
    localparam int unsigned T_SETUP_NS = 100;
    localparam int unsigned T_HOLD_NS = 50;
    localparam int unsigned PULSE_CYC = (T_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned SETUP_CYC = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned HOLD_CYC = (T_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned CNT_W = 8;
    localparam int unsigned N_DEV = 2;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam logic [3:0] ADDR_SHADOW = 4'h8;
    localparam int unsigned CTRL_CH_LSB = 0;
    localparam int unsigned CTRL_EN_BIT = 2;
    localparam int unsigned CTRL_DEV_LSB = 4;
    localparam int unsigned CTRL_STAND_BIT = 8;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_INIT_BIT = 1;
    localparam int unsigned STAT_ACT_LSB = 4;
    localparam int unsigned SHADOW_BITS = 4;

    typedef struct packed {
        logic [1:0] chan;
        logic en_n;
    } latch_word_s;

    typedef struct packed {
        logic cs_n;
        logic wr_n;
        latch_word_s data;
    } mux_pins_s;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SETUP = 4'b0010,
        ST_LOW = 4'b0100,
        ST_HOLD = 4'b1000
    } wr_state_e;
endpackage

/* hdl/mux_pin_port.sv */
// one device's pin driver: strobes and data come straight from flops
// assumes level strobe requests from the sequencer on the same clock
`timescale 1ns/1ps
module mux_pin_port
    import mux_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic stand_i,
    input wire logic cs_i,
    input wire logic wr_i,
    input wire mux_ctrl_pkg::latch_word_s word_i,
    output mux_ctrl_pkg::mux_pins_s pins_o
);
    typedef struct packed {
        mux_pins_s pins;
    } port_state_s;

    port_state_s s_q;
    port_state_s s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.pins.data = word_i;
        if (stand_i)
        begin
            s_d.pins.cs_n = 1'b0;
            s_d.pins.wr_n = 1'b0;
        end
        else
        begin
            s_d.pins.cs_n = ~cs_i;
            s_d.pins.wr_n = ~wr_i;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s_q <= '{pins: '{cs_n: 1'b1, wr_n: 1'b1, data: '{chan: 2'h0, en_n: 1'b1}}};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign pins_o = s_q.pins;
endmodule // mux_pin_port

/* hdl/mux_ctrl.sv */
// host controller for paralleled four-channel latch amplifiers over wishbone
// assumes classic wishbone master; devices share one output node
`timescale 1ns/1ps
module mux_ctrl
    import mux_ctrl_pkg::*;
#(
    parameter int unsigned NDEV = mux_ctrl_pkg::N_DEV
)
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output mux_ctrl_pkg::mux_pins_s [NDEV-1:0] pins_o
);
    import mux_ctrl_pkg::*;

    localparam int unsigned DW = $clog2(NDEV) > 0 ? $clog2(NDEV) : 1;

    typedef struct packed {
        wr_state_e st;
        logic [CNT_W-1:0] cnt;
        logic [1:0] chan;
        logic en;
        logic [DW-1:0] dev;
        logic [DW-1:0] tgt;
        logic phase;
        logic stand;
        logic init;
        logic ack;
        logic [31:0] rdat;
        logic [NDEV-1:0] act;
        logic [NDEV-1:0] cs;
        logic [NDEV-1:0] wr;
        latch_word_s [NDEV-1:0] word;
    } ctrl_state_s;

    ctrl_state_s s_q;
    ctrl_state_s s_d;

    function automatic logic [CNT_W-1:0] cyc_of(input int unsigned n);
        cyc_of = CNT_W'(n);
    endfunction

    function automatic logic [31:0] shadow_of(input logic [NDEV-1:0] act,
                                              input logic [1:0] chan);
        logic [31:0] r;
        r = '0;
        r[NDEV-1:0] = act;
        r[SHADOW_BITS+1:SHADOW_BITS] = chan;
        shadow_of = r;
    endfunction

    wire logic wb_req = cyc_i & stb_i & ~s_q.ack;
    wire logic busy = (s_q.st != ST_IDLE);

    always_comb
    begin
        s_d = s_q;
        s_d.ack = 1'b0;
        if (wb_req)
        begin
            s_d.ack = 1'b1;
            s_d.rdat = '0;
            unique case (adr_i)
                ADDR_CTRL:
                begin
                    s_d.rdat[CTRL_CH_LSB+1:CTRL_CH_LSB] = s_q.chan;
                    s_d.rdat[CTRL_EN_BIT] = s_q.en;
                    s_d.rdat[CTRL_DEV_LSB+DW-1:CTRL_DEV_LSB] = s_q.dev;
                    s_d.rdat[CTRL_STAND_BIT] = s_q.stand;
                    if (we_i && sel_i[0] && !busy)
                    begin
                        // a write always carries code and enable together
                        s_d.chan = dat_i[CTRL_CH_LSB+1:CTRL_CH_LSB];
                        s_d.en = dat_i[CTRL_EN_BIT];
                        s_d.dev = dat_i[CTRL_DEV_LSB+DW-1:CTRL_DEV_LSB];
                        s_d.tgt = '0;
                        s_d.phase = 1'b0;
                        s_d.cnt = cyc_of(SETUP_CYC);
                        s_d.st = ST_SETUP;
                        // first pass turns every device off, the chosen one too, break before make
                        for (int i = 0; i < NDEV; i++)
                        begin
                            s_d.word[i].en_n = 1'b1;
                        end
                    end
                    if (we_i && sel_i[1] && !busy)
                    begin
                        s_d.stand = dat_i[CTRL_STAND_BIT];
                    end
                end
                ADDR_STAT:
                begin
                    s_d.rdat[STAT_BUSY_BIT] = busy;
                    s_d.rdat[STAT_INIT_BIT] = s_q.init;
                    s_d.rdat[STAT_ACT_LSB+NDEV-1:STAT_ACT_LSB] = s_q.act;
                end
                ADDR_SHADOW:
                begin
                    s_d.rdat = shadow_of(s_q.act, s_q.chan);
                end
                default:
                begin
                    s_d.rdat = '0;
                end
            endcase
        end

        unique case (s_q.st)
            ST_IDLE:
            begin
            end
            ST_SETUP:
            begin
                // data settles first; select and strobe fall together later
                s_d.word[s_q.tgt].chan = s_q.chan;
                if (s_q.phase && s_q.tgt == s_q.dev)
                begin
                    s_d.word[s_q.tgt].en_n = ~s_q.en;
                end
                if (s_q.cnt > cyc_of(1))
                begin
                    s_d.cnt = s_q.cnt - cyc_of(1);
                end
                else
                begin
                    s_d.cs[s_q.tgt] = 1'b1;
                    s_d.wr[s_q.tgt] = 1'b1;
                    s_d.cnt = cyc_of(PULSE_CYC > SETUP_CYC ? PULSE_CYC : SETUP_CYC);
                    s_d.st = ST_LOW;
                end
            end
            ST_LOW:
            begin
                if (s_q.cnt > cyc_of(1))
                begin
                    s_d.cnt = s_q.cnt - cyc_of(1);
                end
                else
                begin
                    s_d.wr[s_q.tgt] = 1'b0;
                    s_d.cs[s_q.tgt] = 1'b0;
                    s_d.cnt = cyc_of(HOLD_CYC);
                    s_d.st = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                // word and high strobe kept through hold time
                if (s_q.cnt > cyc_of(1))
                begin
                    s_d.cnt = s_q.cnt - cyc_of(1);
                end
                else if (s_q.tgt != DW'(NDEV - 1))
                begin
                    s_d.tgt = s_q.tgt + DW'(1);
                    s_d.cnt = cyc_of(SETUP_CYC);
                    s_d.st = ST_SETUP;
                end
                else if (!s_q.phase)
                begin
                    // second pass enables only the chosen device
                    s_d.phase = 1'b1;
                    s_d.act = '0;
                    s_d.tgt = '0;
                    s_d.cnt = cyc_of(SETUP_CYC);
                    s_d.st = ST_SETUP;
                end
                else
                begin
                    if (s_q.en)
                    begin
                        s_d.act[s_q.dev] = 1'b1;
                    end
                    s_d.init = 1'b1;
                    s_d.st = ST_IDLE;
                end
            end
            default:
            begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            for (int i = 0; i < NDEV; i++)
            begin
                s_q.word[i].en_n <= 1'b1;
            end
        end
        else
        begin
            s_q <= s_d;
        end
    end

    for (genvar g = 0; g < NDEV; g++)
    begin : g_port
        mux_pin_port u_port (
            .clk_i(clk_i),
            .rstn_i(rstn_i),
            .stand_i(s_q.stand),
            .cs_i(s_q.cs[g]),
            .wr_i(s_q.wr[g]),
            .word_i(s_q.word[g]),
            .pins_o(pins_o[g])
        );
    end

    assign dat_o = s_q.rdat;
    assign ack_o = s_q.ack;
endmodule // mux_ctrl

/* verif/mux_ctrl_sva.sv */
// checker for the latch controller pins and bus answer
// assumes binding into mux_ctrl with the standalone bit left clear
`timescale 1ns/1ps
module mux_ctrl_sva
    import mux_ctrl_pkg::*;
#(
    parameter int unsigned NDEV = 2
)
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire mux_ctrl_pkg::mux_pins_s [NDEV-1:0] pins_o
);
    logic [CNT_W-1:0] low_q;
    logic [NDEV-1:0] on_v;
    mux_pins_s p;
    assign p = pins_o[0];
    always_comb
    begin
        for (int i = 0; i < NDEV; i++)
            on_v[i] = !pins_o[i].data.en_n;
    end
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            low_q <= '0;
        else
            low_q <= p.wr_n ? '0 : low_q + 1'b1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    property p_cs_wr; p.cs_n == p.wr_n; endproperty
    a_cs_wr: assert property (p_cs_wr) else $error("cs and wr differ");
    property p_pulse; $rose(p.wr_n) |-> low_q >= PULSE_CYC; endproperty
    a_pulse: assert property (p_pulse) else $error("strobe too short");
    property p_setup; $fell(p.wr_n) |-> $stable(p.data); endproperty
    a_setup: assert property (p_setup) else $error("data not set up");
    property p_low; !p.wr_n && !$past(p.wr_n) |-> $stable(p.data); endproperty
    a_low: assert property (p_low) else $error("data moved in strobe");
    property p_hold; $rose(p.wr_n) |-> (p.wr_n && $stable(p.data))[*8]; endproperty
    a_hold: assert property (p_hold) else $error("hold broken");
    property p_one; $countones(on_v) <= 1; endproperty
    a_one: assert property (p_one) else $error("two outputs on");
    property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
    a_ack: assert property (p_ack) else $error("bad ack pulse");
    property p_noreq; !(cyc_i && stb_i) |=> !ack_o; endproperty
    a_noreq: assert property (p_noreq) else $error("ack without request");
    c_ack: cover property (ack_o);
    c_pulse: cover property ($rose(p.wr_n));
    c_on: cover property (on_v != '0);
endmodule // mux_ctrl_sva
bind mux_ctrl mux_ctrl_sva #(.NDEV(NDEV)) mux_ctrl_sva_i (.clk_i(clk_i), .rstn_i(rstn_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .pins_o(pins_o));

/* verif/latch_amp_model.sv */
// behavioural latch of one four-channel amplifier
// assumes pins straight from the controller, no clock, no reset
`timescale 1ns/1ps
module latch_amp_model
    import mux_ctrl_pkg::*;
(
    input wire mux_ctrl_pkg::mux_pins_s pins_i,
    output logic [1:0] chan_o,
    output logic on_o
);
    latch_word_s word_q;
    always_latch
    begin
        if (!pins_i.cs_n && !pins_i.wr_n)
            word_q <= pins_i.data;
    end
    assign chan_o = word_q.chan;
    assign on_o = !word_q.en_n;
endmodule // latch_amp_model

/* verif/testbench.sv */
// bench: wishbone master tasks driving the controller and two latch models
// assumes mux_ctrl with NDEV equal to N_DEV
`timescale 1ns/1ps
module testbench;
    import mux_ctrl_pkg::*;
    logic clk_i, rstn_i, cyc, stb, we, ack;
    logic [3:0] adr, sel;
    logic [31:0] wdat, rdat, q;
    mux_pins_s [N_DEV-1:0] pins;
    logic [1:0] chan [N_DEV];
    logic [N_DEV-1:0] on;
    int n_errors = 0;
    int checks = 0;
    mux_ctrl #(.NDEV(N_DEV)) mux_ctrl_i (.clk_i(clk_i), .rstn_i(rstn_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
        .ack_o(ack), .pins_o(pins));
    for (genvar g = 0; g < N_DEV; g++)
    begin : g_dev
        latch_amp_model latch_amp_model_i (.pins_i(pins[g]), .chan_o(chan[g]), .on_o(on[g]));
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h3;
        wdat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50)
        begin
            n_errors++;
            final_report();
        end
    endtask
    task automatic idle();
        int n;
        n = 0;
        do
        begin
            wb(1'b0, ADDR_STAT, 32'h0);
            n++;
        end
        while (q[STAT_BUSY_BIT] !== 1'b0 && n < 400);
        if (n >= 400)
        begin
            n_errors++;
            final_report();
        end
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial
    begin
        {cyc, stb, we, adr, sel, wdat} = '0;
        rstn_i = 1'b0;
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'b1;
        chk({pins[0].cs_n, pins[0].wr_n, pins[0].data.en_n}, 3'h7);
        for (int d = 0; d < N_DEV; d++)
        begin
            for (int c = 0; c < 4; c++)
            begin
                wb(1'b1, ADDR_CTRL, (d << CTRL_DEV_LSB) | (1 << CTRL_EN_BIT) | c);
                idle();
                chk(on, 1 << d);
                chk({chan[0], chan[1]}, {c[1:0], c[1:0]});
                wb(1'b0, ADDR_SHADOW, 32'h0);
                chk(q[5:0], (c << 4) | (1 << d));
            end
        end
        $display("test select done");
        wb(1'b1, ADDR_CTRL, 32'h5);
        wb(1'b1, ADDR_CTRL, 32'h6);
        idle();
        chk({on, chan[0]}, 4'h5);
        $display("test busy done");
        wb(1'b1, ADDR_CTRL, 32'h12);
        idle();
        chk({on, chan[1]}, 4'h2);
        wb(1'b0, 4'hc, 32'h0);
        chk(q, 32'h0);
        wb(1'b0, ADDR_CTRL, 32'h0);
        chk(q, 32'h12);
        wb(1'b0, ADDR_STAT, 32'h0);
        chk(q, 32'h1 << STAT_INIT_BIT);
        $display("test disable done");
        final_report();
    end
endmodule // testbench
